// File: shared/ptd_pkg.sv
package ptd_pkg;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] PTD_IDX_PLL_MOD    = 8'h3a;
  localparam logic [7:0] PTD_IDX_TICK_CTRL  = 8'h3b;
  localparam logic [7:0] PTD_IDX_CLK_SEL    = 8'h39;
  localparam logic [7:0] PTD_IDX_PROTECT    = 8'h3f;
  localparam logic [7:0] PTD_IDX_STATUS     = 8'h37;
  localparam logic [7:0] PTD_IDX_IRQ_STAT   = 8'h40;
  localparam logic [7:0] PTD_IDX_IRQ_MASK   = 8'h41;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         PTD_FM_LSB         = 4;
  localparam int         PTD_CS_PLL_SOURCE_SELECT_BIT  = 7;
  localparam int         PTD_CS_PSTOP_BIT   = 6;
  localparam int         PTD_CS_TSEL_BIT    = 1;
  localparam int         PTD_ST_LOCK_BIT    = 1;
  localparam int         PTD_ST_OSCUP_BIT   = 0;
  localparam int         PTD_IRQ_TICK_BIT   = 0;
  localparam int         PTD_IRQ_OSCLOST_BIT = 1;
  localparam logic [7:0] PTD_TICK_RST       = 8'h00;
  localparam logic [1:0] PTD_FM_RST         = 2'h0;
  localparam logic       PTD_PLL_SOURCE_SELECT_RST     = 1'b1;
  localparam logic       PTD_WRITE_PROTECT_BIT_RST       = 1'b0;
  localparam logic [1:0] PTD_IRQ_RST        = 2'h0;
  localparam logic [3:0] PTD_FM_DIV_LAST    = 4'hf;

  // Modulation amplitude codes
  typedef enum logic [1:0] {
    PTD_FM_OFF, PTD_FM_PM1, PTD_FM_PM2, PTD_FM_PM4
  } ptd_fm_amp_t;

  // Tick control layout
  typedef struct packed {
    logic       decimal_divider_select;
    logic [2:0] tick_prescale_field;
    logic [3:0] tick_modulus_field;
  } ptd_tick_ctrl_t;

  // Prescaler length in source-clock edges
  function automatic logic [17:0] ptd_prescale(input logic dec, input logic [2:0] code);
    logic [17:0] v;
    v = 18'h0_0000;
    if (dec) begin
      case (code)
        3'h0:    v = 18'd1000;
        3'h1:    v = 18'd2000;
        3'h2:    v = 18'd5000;
        3'h3:    v = 18'd10000;
        3'h4:    v = 18'd20000;
        3'h5:    v = 18'd50000;
        3'h6:    v = 18'd100000;
        default: v = 18'd200000;
      endcase
    end else if (code != 3'h0) begin
      v = 18'h0_0001 << (5'd9 + {2'b00, code});
    end
    return v;
  endfunction

endpackage

// File: logic/ptd_top.sv
`timescale 1ns/1ns
module ptd_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources, one-cycle pulse per source edge
  input  wire logic        internal_rc_clock,
  input  wire logic        oscillator_clock,
  input  wire logic        pll_ref_tick,
  // Unit status events and mode
  input  wire logic        osc_up_event,
  input  wire logic        osc_lost_event,
  input  wire logic        pll_lock_event,
  input  wire logic        stop_mode,
  // Outputs
  output ptd_pkg::ptd_fm_amp_t vco_modulation_amp,
  output logic             vco_modulation_step,
  output logic             periodic_tick,
  output logic             irq
);
  import ptd_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  ptd_tick_ctrl_t tick_ctrl_r;
  ptd_fm_amp_t    fm_amp_r;
  logic           pll_source_select_r;
  logic           pseudo_stop_enable_r;
  logic           tick_clock_select_r;
  logic           write_protect_bit_r;
  logic           oscillator_up_flag_r;
  logic           lock_flag_r;
  logic [1:0]     irq_stat_r;
  logic [1:0]     irq_mask_r;
  logic [31:0]    prdata_r;
  logic           pready_r;
  logic           pslverr_r;
  logic [17:0]    presc_cnt_r;
  logic [3:0]     mod_cnt_r;
  logic [3:0]     fm_div_r;
  logic           fm_step_r;
  logic           tick_r;
  logic           irq_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] idx;
  logic       wr_en;
  logic       wr_pll;
  logic       wr_tick;
  logic       wr_cs;
  logic       wr_write_protect_bit;
  logic       wr_istat;
  logic       wr_imask;
  logic       pll_write_ok;
  logic       mapped;

  assign idx      = paddr[9:2];
  assign wr_en    = psel & penable & pwrite & pready_r;
  assign wr_pll   = wr_en & (idx == PTD_IDX_PLL_MOD);
  assign wr_tick  = wr_en & (idx == PTD_IDX_TICK_CTRL);
  assign wr_cs    = wr_en & (idx == PTD_IDX_CLK_SEL) & ~write_protect_bit_r;
  assign wr_write_protect_bit  = wr_en & (idx == PTD_IDX_PROTECT);
  assign wr_istat = wr_en & (idx == PTD_IDX_IRQ_STAT);
  assign wr_imask = wr_en & (idx == PTD_IDX_IRQ_MASK);
  // Blocked writes still complete on the bus, they just change nothing
  assign pll_write_ok = wr_pll & ~write_protect_bit_r & pll_source_select_r;

  always_comb begin
    mapped = 1'b1;
    if (idx == PTD_IDX_PLL_MOD) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_TICK_CTRL) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_CLK_SEL) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_PROTECT) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_STATUS) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_IRQ_STAT) begin
      mapped = 1'b1;
    end else if (idx == PTD_IDX_IRQ_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Answer one cycle after setup; read data captured during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        if (idx == PTD_IDX_PLL_MOD) begin
          prdata_r <= {26'h0, fm_amp_r, 4'h0};
        end else if (idx == PTD_IDX_TICK_CTRL) begin
          prdata_r <= {24'h0, tick_ctrl_r};
        end else if (idx == PTD_IDX_CLK_SEL) begin
          prdata_r <= {24'h0, pll_source_select_r, pseudo_stop_enable_r, 4'h0,
                       tick_clock_select_r, 1'b0};
        end else if (idx == PTD_IDX_PROTECT) begin
          prdata_r <= {31'h0, write_protect_bit_r};
        end else if (idx == PTD_IDX_STATUS) begin
          prdata_r <= {30'h0, lock_flag_r, oscillator_up_flag_r};
        end else if (idx == PTD_IDX_IRQ_STAT) begin
          prdata_r <= {30'h0, irq_stat_r};
        end else if (idx == PTD_IDX_IRQ_MASK) begin
          prdata_r <= {30'h0, irq_mask_r};
        end else begin
          prdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // PLL modulation control
  // ---------------------------------------------------------------
  // Bus-clock limit and filter exclusivity are software's job; nothing checks them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_amp_r <= PTD_FM_OFF;
    end else if (pll_write_ok) begin
      fm_amp_r <= ptd_fm_amp_t'(pwdata[PTD_FM_LSB +: 2]);
    end
  end

  // Status flags: an accepted PLL write clears them, a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_up_flag_r <= 1'b0;
      lock_flag_r          <= 1'b0;
    end else begin
      if (osc_up_event) begin
        oscillator_up_flag_r <= 1'b1;
      end else if (osc_lost_event | pll_write_ok) begin
        oscillator_up_flag_r <= 1'b0;
      end
      if (pll_lock_event) begin
        lock_flag_r <= 1'b1;
      end else if (pll_write_ok) begin
        lock_flag_r <= 1'b0;
      end
    end
  end

  // Modulation step every sixteen reference edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_div_r  <= 4'h0;
      fm_step_r <= 1'b0;
    end else begin
      fm_step_r <= 1'b0;
      if (fm_amp_r == PTD_FM_OFF) begin
        fm_div_r <= 4'h0;
      end else if (pll_ref_tick) begin
        fm_div_r  <= fm_div_r + 4'h1;
        fm_step_r <= (fm_div_r == PTD_FM_DIV_LAST);
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock select and protection
  // ---------------------------------------------------------------
  logic tsel_nxt;
  always_comb begin
    tsel_nxt = tick_clock_select_r;
    if (wr_cs) begin
      tsel_nxt = pwdata[PTD_CS_TSEL_BIT] & oscillator_up_flag_r;
    end
    if (osc_lost_event | pll_write_ok) begin
      tsel_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_source_select_r  <= PTD_PLL_SOURCE_SELECT_RST;
      pseudo_stop_enable_r <= 1'b0;
      tick_clock_select_r  <= 1'b0;
      write_protect_bit_r  <= PTD_WRITE_PROTECT_BIT_RST;
    end else begin
      tick_clock_select_r <= tsel_nxt;
      if (wr_cs) begin
        pseudo_stop_enable_r <= pwdata[PTD_CS_PSTOP_BIT];
        pll_source_select_r  <= pwdata[PTD_CS_PLL_SOURCE_SELECT_BIT];
      end
      if (wr_write_protect_bit) begin
        write_protect_bit_r <= pwdata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Periodic tick timer
  // ---------------------------------------------------------------
  logic        src_edge;
  logic        halted;
  logic        timer_off;
  logic        restart;
  logic [17:0] presc_len;
  logic        presc_wrap;
  logic        expire;

  assign src_edge   = tick_clock_select_r ? oscillator_clock : internal_rc_clock;
  assign halted     = stop_mode & ~(pseudo_stop_enable_r & tick_clock_select_r);
  assign timer_off  = ~tick_ctrl_r.decimal_divider_select &
                      (tick_ctrl_r.tick_prescale_field == 3'h0);
  assign restart    = wr_tick | (tsel_nxt != tick_clock_select_r);
  assign presc_len  = ptd_prescale(tick_ctrl_r.decimal_divider_select,
                                   tick_ctrl_r.tick_prescale_field);
  assign presc_wrap = (presc_cnt_r == presc_len - 18'h0_0001);
  assign expire     = src_edge & ~halted & ~timer_off & presc_wrap &
                      (mod_cnt_r == tick_ctrl_r.tick_modulus_field);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ctrl_r <= ptd_tick_ctrl_t'(PTD_TICK_RST);
    end else if (wr_tick) begin
      tick_ctrl_r <= ptd_tick_ctrl_t'(pwdata[7:0]);
    end
  end

  // Counter keeps its value across stop; only restarts and the binary prescale code zero clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= 18'h0_0000;
      mod_cnt_r   <= 4'h0;
    end else if (restart | timer_off) begin
      presc_cnt_r <= 18'h0_0000;
      mod_cnt_r   <= 4'h0;
    end else if (src_edge & ~halted) begin
      if (presc_wrap) begin
        presc_cnt_r <= 18'h0_0000;
        mod_cnt_r   <= expire ? 4'h0 : mod_cnt_r + 4'h1;
      end else begin
        presc_cnt_r <= presc_cnt_r + 18'h0_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: write one to clear, set wins
  // ---------------------------------------------------------------
  logic [1:0] ev;
  assign ev = {osc_lost_event, expire & ~restart};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= PTD_IRQ_RST;
      irq_mask_r <= PTD_IRQ_RST;
      tick_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_istat ? pwdata[1:0] : 2'b00)) | ev;
      if (wr_imask) begin
        irq_mask_r <= pwdata[1:0];
      end
      tick_r <= ev[PTD_IRQ_TICK_BIT];
      irq_r  <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign vco_modulation_amp  = fm_amp_r;
  assign vco_modulation_step = fm_step_r;
  assign periodic_tick       = tick_r;
  assign irq                 = irq_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_pll_write_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pll && (write_protect_bit_r || !pll_source_select_r) |=> $stable(fm_amp_r))
    else $error("blocked PLL write changed modulation field");

  a_pll_clear_flags: assert property (@(posedge pclk) disable iff (!presetn)
    pll_write_ok && !osc_up_event && !pll_lock_event |=> !oscillator_up_flag_r && !lock_flag_r)
    else $error("accepted PLL write left status flags set");

  a_fm_step_rate: assert property (@(posedge pclk) disable iff (!presetn)
    fm_step_r |-> fm_div_r == 4'h0 && fm_amp_r != PTD_FM_OFF && $past(pll_ref_tick))
    else $error("modulation step out of sixteen-edge cadence");

  a_tick_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wr_tick |=> presc_cnt_r == 18'h0_0000 && mod_cnt_r == 4'h0)
    else $error("tick control write did not restart timeout");

  a_sel_restart: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(tick_clock_select_r) |-> presc_cnt_r == 18'h0_0000 && mod_cnt_r == 4'h0)
    else $error("clock select change did not restart timeout");

  a_stop_halt: assert property (@(posedge pclk) disable iff (!presetn)
    halted && !restart |=> $stable(presc_cnt_r) && $stable(mod_cnt_r))
    else $error("tick counter moved while halted in stop");

  a_off_code: assert property (@(posedge pclk) disable iff (!presetn)
    timer_off |=> presc_cnt_r == 18'h0_0000 && mod_cnt_r == 4'h0 && !tick_r)
    else $error("timer ran with prescale code zero in binary mode");

  a_osc_loss_sel: assert property (@(posedge pclk) disable iff (!presetn)
    osc_lost_event |=> !tick_clock_select_r ##1 !tick_clock_select_r || $past(wr_cs))
    else $error("oscillator loss did not clear tick clock select");

  a_expire_flag: assert property (@(posedge pclk) disable iff (!presetn)
    expire && !restart |=> irq_stat_r[PTD_IRQ_TICK_BIT] && tick_r ##1 irq == irq_mask_r[0])
    else $error("expiry did not raise tick flag");

endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import ptd_pkg::*;

  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  localparam logic [31:0] ONE     = 32'h0000_0001;
  localparam logic [31:0] ZERO    = 32'h0000_0000;
  localparam int          DEC_TAB [8] = '{1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
  logic                   pclk, presetn, psel, penable, pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, err;
  logic                   rc_clk, osc_clk, ref_tick, up_ev, lost_ev, lock_ev, stop_mode;
  ptd_fm_amp_t            amp;
  logic                   step, tick, irq;
  logic [7:0]             cfg;
  int                     num_errors, checks, n, k, steps;

  ptd_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_rc_clock(rc_clk), .oscillator_clock(osc_clk), .pll_ref_tick(ref_tick),
    .osc_up_event(up_ev), .osc_lost_event(lost_ev), .pll_lock_event(lock_ev),
    .stop_mode(stop_mode), .vco_modulation_amp(amp), .vco_modulation_step(step),
    .periodic_tick(tick), .irq(irq)
  );

  // Free-running bus clock, 40 ns period
  always #20 pclk = ~pclk;

  // Count modulation step pulses as they are seen at the clock edge
  always @(posedge pclk) begin
    if (presetn !== 1'b1) begin
      steps <= 0;
    end else if (step === 1'b1) begin
      steps <= steps + 1;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 20) begin
      @(posedge pclk);
      w++;
    end
    check({31'h0, pready}, ONE);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  // Edges up to and including the next sampled tick, capped at limit
  task automatic wait_tick(input int limit);
    n = 1;
    @(posedge pclk);
    while (tick !== 1'b1 && n < limit) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Distance between two ticks, with a source pulse on every cycle
  task automatic period(input int exp);
    wait_tick(exp + 100);
    wait_tick(exp + 100);
    check(32'(n), 32'(exp));
  endtask

  // A restart must push the next tick a whole period away
  task automatic restart_window;
    wait_tick(1200);
    repeat (500) @(posedge pclk);
  endtask

  task automatic pulse_up_lock;
    up_ev   <= 1'b1;
    lock_ev <= 1'b1;
    @(posedge pclk);
    up_ev   <= 1'b0;
    lock_ev <= 1'b0;
  endtask

  function automatic int exp_period(input logic [7:0] c);
    int pre;
    if (c[7]) pre = DEC_TAB[c[6:4]];
    else pre = (c[6:4] == 3'h0) ? 0 : (1 << (9 + c[6:4]));
    return pre * (c[3:0] + 1);
  endfunction

  // ------------------------------------------------------------
  // Watchdog: the whole sequence needs well under this many cycles
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, rc_clk, osc_clk, ref_tick} = 8'h00;
    {up_ev, lost_ev, lock_ev, stop_mode} = 4'h0;
    paddr = 12'h000;
    pwdata = ZERO;
    void'($urandom(32'h3aca));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped word
    rdchk(PTD_IDX_TICK_CTRL, ZERO);
    rdchk(PTD_IDX_CLK_SEL, 32'h0000_0080);
    rdchk(PTD_IDX_PLL_MOD, ZERO);
    rdchk(8'h00, ZERO);
    check({31'h0, err}, ONE);
    // Amplitude codes, and the status clear on an accepted write
    pulse_up_lock();
    rdchk(PTD_IDX_STATUS, 32'h0000_0003);
    for (k = 0; k < 4; k++) begin
      wr(PTD_IDX_PLL_MOD, {2'b00, 2'(k), 4'h0});
      repeat (2) @(posedge pclk);
      check({30'h0, amp}, 32'(k));
      rdchk(PTD_IDX_PLL_MOD, {26'h0, 2'(k), 4'h0});
    end
    rdchk(PTD_IDX_STATUS, ZERO);
    // Step pulses at one per sixteen reference edges
    n = steps;
    ref_tick <= 1'b1;
    repeat (160) @(posedge pclk);
    ref_tick <= 1'b0;
    repeat (4) @(posedge pclk);
    check(32'(steps - n), 32'(10));
    // Refused writes: protection on, then PLL not selected
    pulse_up_lock();
    wr(PTD_IDX_PROTECT, 8'h01);
    rdchk(PTD_IDX_PROTECT, ONE);
    wr(PTD_IDX_PLL_MOD, 8'h10);
    wr(PTD_IDX_CLK_SEL, 8'h00);
    rdchk(PTD_IDX_PLL_MOD, 32'h0000_0030);
    rdchk(PTD_IDX_CLK_SEL, 32'h0000_0080);
    wr(PTD_IDX_PROTECT, 8'h00);
    wr(PTD_IDX_CLK_SEL, 8'h00);
    wr(PTD_IDX_PLL_MOD, 8'h10);
    rdchk(PTD_IDX_PLL_MOD, 32'h0000_0030);
    rdchk(PTD_IDX_STATUS, 32'h0000_0003);
    wr(PTD_IDX_CLK_SEL, 8'h80);
    pulse_up_lock();
    // Divide factors: fixed corners, then random settings
    rc_clk <= 1'b1;
    wr(PTD_IDX_TICK_CTRL, 8'h10);
    period(1024);
    wr(PTD_IDX_TICK_CTRL, 8'h80);
    period(1000);
    wr(PTD_IDX_TICK_CTRL, 8'h11);
    period(2048);
    for (k = 0; k < 3; k++) begin
      cfg = {1'($urandom), 3'($urandom % 2), 4'($urandom % 2)};
      if (!cfg[7]) cfg[6:4] = cfg[6:4] + 3'h1;
      wr(PTD_IDX_TICK_CTRL, cfg);
      period(exp_period(cfg));
    end
    wr(PTD_IDX_TICK_CTRL, 8'h0f);
    wait_tick(2500);
    check(32'(n >= 2500), ONE);
    // Restarts: control write, select change, oscillator loss
    wr(PTD_IDX_TICK_CTRL, 8'h10);
    restart_window();
    wr(PTD_IDX_TICK_CTRL, 8'h10);
    wait_tick(1200);
    check(32'(n > 1000 && n < 1100), ONE);
    osc_clk <= 1'b1;
    restart_window();
    wr(PTD_IDX_CLK_SEL, 8'h82);
    wait_tick(1200);
    check(32'(n > 1000 && n < 1100), ONE);
    restart_window();
    lost_ev <= 1'b1;
    @(posedge pclk);
    lost_ev <= 1'b0;
    wait_tick(1200);
    check(32'(n > 1000 && n < 1100), ONE);
    rdchk(PTD_IDX_CLK_SEL, 32'h0000_0080);
    rdchk(PTD_IDX_IRQ_STAT, 32'h0000_0003);
    wr(PTD_IDX_CLK_SEL, 8'h82);
    rdchk(PTD_IDX_CLK_SEL, 32'h0000_0080);
    // Source selection
    pulse_up_lock();
    wr(PTD_IDX_CLK_SEL, 8'h82);
    rc_clk <= 1'b0;
    period(1024);
    osc_clk <= 1'b0;
    rc_clk <= 1'b1;
    wait_tick(2200);
    check(32'(n >= 2200), ONE);
    // Stop mode: halts unless pseudo-stop with the oscillator source
    stop_mode <= 1'b1;
    osc_clk <= 1'b1;
    rc_clk <= 1'b0;
    wait_tick(2200);
    check(32'(n >= 2200), ONE);
    wr(PTD_IDX_CLK_SEL, 8'hc2);
    period(1024);
    wr(PTD_IDX_CLK_SEL, 8'hc0);
    rc_clk <= 1'b1;
    wait_tick(2200);
    check(32'(n >= 2200), ONE);
    // Interrupt raised, cleared, then masked
    stop_mode <= 1'b0;
    wr(PTD_IDX_IRQ_STAT, 8'h03);
    wr(PTD_IDX_IRQ_MASK, 8'h01);
    rdchk(PTD_IDX_IRQ_MASK, ONE);
    wait_tick(1200);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, ONE);
    wr(PTD_IDX_TICK_CTRL, 8'h00);
    wr(PTD_IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, ZERO);
    rdchk(PTD_IDX_IRQ_STAT, ZERO);
    wr(PTD_IDX_IRQ_MASK, 8'h00);
    wr(PTD_IDX_TICK_CTRL, 8'h10);
    wait_tick(1200);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, ZERO);
    rdchk(PTD_IDX_IRQ_STAT, ONE);
    end_of_test();
  end
endmodule
